//--- sim/shf_rx_model.sv
// Behavioural link receiver: header checks, stream word assembly, extended multiblock count
`timescale 1ns/1ps
`default_nettype none
module shf_rx_model (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Line side
  input wire logic sysref_i,
  input wire logic vld_i,
  input wire logic [65:0] blk_i,
  input wire logic local_extended_multiblock_clock_i,
  input wire logic [7:0] em1_i,
  // Results
  output logic word_vld_o,
  output logic [31:0] word_o,
  output logic chk_o,
  output logic bad_o
);
  logic [4:0] idx_r;
  logic [7:0] mb_r;
  logic [30:0] sh_r;
  logic sr_r;
  logic pend_r;
  logic [4:0] i;
  logic [7:0] m;
  // A pending restart makes the next block the first of everything
  assign i = pend_r ? 5'h00 : idx_r;
  assign m = pend_r ? 8'h00 : mb_r;
  // One step per received block; boundaries are taken as already found
  always_ff @(posedge sys_clk_i) begin
    word_vld_o <= 1'b0;
    chk_o <= vld_i;
    sr_r <= sysref_i;
    if (sysref_i && !sr_r) begin
      pend_r <= 1'b1;
    end
    if (vld_i) begin
      pend_r <= 1'b0;
      mb_r <= m;
      idx_r <= i + 5'h01;
      if (i != 5'h1f) begin
        sh_r[i] <= blk_i[64];
      end
      // Equal header bits would mean lost alignment
      bad_o <= (blk_i[65] == blk_i[64]) || (local_extended_multiblock_clock_i != (i == 5'h00 && m == 8'h00));
      if (i == 5'h1f) begin
        word_o <= {blk_i[64], sh_r};
        word_vld_o <= 1'b1;
        mb_r <= (m == em1_i) ? 8'h00 : m + 8'h01;
      end
    end
    if (rst_i) begin
      word_vld_o <= 1'b0;
      chk_o <= 1'b0;
      bad_o <= 1'b0;
      pend_r <= 1'b0;
      idx_r <= 5'h00;
      mb_r <= 8'h00;
    end
  end
endmodule
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench for the sync header stream framer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk_i, rst_i, sysref_i, blk_valid_i, reg_wr_i, reg_rd_i;
  logic tx_valid_o, local_extended_multiblock_clock_o, word_vld, chk, bad, fec, rd_pend;
  logic [63:0] blk_data_i;
  logic [65:0] tx_block_o;
  logic [3:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, word;
  logic [7:0] em1, mbi;
  logic [25:0] crc_run, crc_prev, fec_run, fec_prev;
  logic [31:0] wq[$], mq[$], rq[$];
  logic [63:0] dq[$];
  integer seed;
  int err_total, num_checks;
  // Free running 100 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  shf_top shf_top_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .sysref_i(sysref_i),
    .blk_valid_i(blk_valid_i), .blk_data_i(blk_data_i), .tx_valid_o(tx_valid_o),
    .tx_block_o(tx_block_o), .local_extended_multiblock_clock_o(local_extended_multiblock_clock_o), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o));
  shf_rx_model shf_rx_model_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .sysref_i(sysref_i),
    .vld_i(tx_valid_o), .blk_i(tx_block_o), .local_extended_multiblock_clock_i(local_extended_multiblock_clock_o), .em1_i(em1),
    .word_vld_o(word_vld), .word_o(word), .chk_o(chk), .bad_o(bad));
  // MSB-first LFSR, bit 63 enters first, for either parity width
  function automatic logic [25:0] lfsr(input logic [25:0] s, input logic [63:0] d,
    input int w, input logic [25:0] p);
    logic fb;
    for (int k = 63; k >= 0; k--) begin
      fb = d[k] ^ s[w-1];
      s = ((s << 1) ^ (fb ? p : 26'h000_0000)) & ((26'h000_0001 << w) - 26'h000_0001);
    end
    return s;
  endfunction
  // Expected stream word from format, end flag and previous parity
  function automatic logic [31:0] mk_word(input logic f, input logic eoe, input logic [25:0] p);
    logic [31:0] w;
    w = f ? 32'h8000_0000 : 32'h80a8_8888;
    for (int k = 0; k < 26; k++) begin
      if (f && k < 22) w[k] = p[25-k];
      else if (f) w[k+1] = p[25-k];
      if (!f && k < 12) w[k+k/3] = p[11-k];
    end
    w[22] = eoe;
    return w;
  endfunction
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task print_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe; the watcher checks them there
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    rq.push_back(e);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
  endtask
  // Back to back blocks; only whole multiblocks produce a stream word
  task automatic send(input int n, input logic msk);
    logic [63:0] d;
    for (int b = 0; b < n; b++) begin
      if (b == 0 && n == 32) begin
        wq.push_back(mk_word(fec, mbi == em1, fec ? fec_prev : crc_prev));
        mq.push_back(msk ? 32'hf840_0000 : 32'hffff_ffff);
      end
      d = {$random(seed), $random(seed)};
      dq.push_back(d);
      crc_run = lfsr(crc_run, d, 12, 26'h000_030f);
      fec_run = lfsr(fec_run, d, 26, 26'h022_0211);
      @(posedge sys_clk_i);
      blk_valid_i <= 1'b1;
      blk_data_i <= d;
    end
    @(posedge sys_clk_i);
    blk_valid_i <= 1'b0;
    if (n == 32) begin
      crc_prev = crc_run;
      fec_prev = fec_run;
      crc_run = 26'h000_0000;
      fec_run = 26'h000_0000;
      mbi = (mbi == em1) ? 8'h00 : mbi + 8'h01;
    end
  endtask
  // Output watcher; old values are sampled before this edge's updates land
  always @(posedge sys_clk_i) begin
    if (tx_valid_o === 1'b1)
      check("tx_data", tx_block_o[63:0], dq.size() ? dq.pop_front() : ~tx_block_o[63:0]);
    if (chk === 1'b1) check("hdr_local_extended_multiblock_clock", {63'h0, bad}, 64'h0);
    // Read data in the cycle after the strobe, zero in every other cycle
    if (rd_pend) check("reg_rdata", {32'h0, reg_rdata_o}, {32'h0, rq.pop_front()});
    else if (rst_i === 1'b0) check("rdata_idle", {32'h0, reg_rdata_o}, 64'h0);
    rd_pend = (reg_rd_i === 1'b1);
    if (word_vld === 1'b1 && wq.size() == 0) check("stream_extra", 64'h1, 64'h0);
    if (word_vld === 1'b1 && wq.size() != 0) begin
      check("stream_word", {32'h0, word & mq[0]}, {32'h0, wq[0] & mq[0]});
      check("pilot", {59'h0, word[31:27]}, 64'h10);
      void'(wq.pop_front());
      void'(mq.pop_front());
    end
  end
  // Whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    err_total++;
    $display("watchdog expired");
    print_verdict();
  end
  initial begin
    seed = 32'h9f19;
    {rst_i, sysref_i, blk_valid_i, reg_wr_i, reg_rd_i, fec} = 6'h20;
    rd_pend = 1'b0;
    {blk_data_i, reg_addr_i, reg_wdata_i, em1, mbi} = '0;
    {crc_run, crc_prev, fec_run, fec_prev} = '0;
    err_total = 0;
    num_checks = 0;
    repeat (16) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd(shf_pkg::REG_CTRL, 32'h0000_0000);
    repeat (3) send(32, 1'b0);
    rd(shf_pkg::REG_STAT, 32'h0000_0000);
    $display("test crc_e1 done");
    // Correction format, three multiblocks per extended multiblock
    wr(shf_pkg::REG_CTRL, 32'h0000_0202);
    fec = 1'b1;
    em1 <= 8'h02;
    rd(shf_pkg::REG_CTRL, 32'h0000_0202);
    rd(4'h8, 32'h0000_0000);
    send(32, 1'b1);
    repeat (3) send(32, 1'b0);
    $display("test fec_e3 done");
    // Restart in mid multiblock, back to CRC with two per extended multiblock
    send(10, 1'b0);
    // Unsupported mode 1 must behave as CRC
    wr(shf_pkg::REG_CTRL, 32'h0000_0101);
    fec = 1'b0;
    em1 <= 8'h01;
    @(posedge sys_clk_i);
    // Single SYSREF pulse, never a periodic one
    sysref_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    sysref_i <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
    rd(shf_pkg::REG_STAT, 32'h0001_8000);
    mbi = 8'h00;
    crc_run = 26'h000_0000;
    fec_run = 26'h000_0000;
    send(32, 1'b1);
    repeat (2) send(32, 1'b0);
    rd(shf_pkg::REG_STAT, {15'h0000, 1'b1, 1'b0, 2'h0, mbi, 5'h00});
    repeat (10) @(posedge sys_clk_i);
    check("queues_empty", wq.size() + dq.size() + rq.size(), 64'h0);
    $display("test sysref done");
    print_verdict();
  end
endmodule
`default_nettype wire

//--- verilog/shf_par_gen.sv
// Serial LFSR parity generator, one 64-bit block per enable
`timescale 1ns/1ps
`default_nettype none
module shf_par_gen #(
  parameter int W = 12,
  parameter logic [W-1:0] POLY = '0
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Block feed and parity
  shf_par_if.gen pif
);
  logic [W-1:0] state_r;
  logic [W-1:0] state_nxt;
  logic [W-1:0] s;
  logic fb;

  // Block bits enter MSB first; start clears the seed so each multiblock starts at zero
  always_comb begin
    s = pif.start ? '0 : state_r;
    fb = 1'b0;
    for (int i = shf_pkg::BLK_W - 1; i >= 0; i--) begin
      fb = s[W-1] ^ pif.data[i];
      s = {s[W-2:0], 1'b0} ^ (fb ? POLY : '0);
    end
    pif.par_nxt = s;
    state_nxt = pif.en ? s : state_r;
  end

  // State register
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end
endmodule
`default_nettype wire

//--- verilog/shf_par_if.sv
// Interface between the framer and a parity generator
`timescale 1ns/1ps
`default_nettype none
interface shf_par_if #(parameter int W = 12);
  logic start;
  logic en;
  logic [shf_pkg::BLK_W-1:0] data;
  logic [W-1:0] par_nxt;
  modport gen (input start, input en, input data, output par_nxt);
  modport user (output start, output en, output data, input par_nxt);
endinterface
`default_nettype wire

//--- verilog/shf_pkg.sv
// Constants and layouts for the sync header stream framing block
`default_nettype none
package shf_pkg;
  // Block and multiblock geometry
  localparam int BLK_W = 64;
  localparam int SH_W = 2;
  localparam int MB_BLOCKS = 32;
  localparam int IDX_W = 5;
  localparam int EMB_W = 8;
  localparam int WORD_W = 32;
  // Parity generators
  localparam int CRC_W = 12;
  localparam logic [11:0] CRC_KOOP = 12'h0987;
  localparam logic [12:0] CRC_FULL = {CRC_KOOP, 1'b1};
  localparam logic [11:0] CRC_POLY = CRC_FULL[11:0];
  localparam int FEC_W = 26;
  localparam logic [25:0] FEC_POLY = 26'h022_0211;
  // Header stream mode select codes
  localparam logic [1:0] SHM_CRC = 2'h0;
  localparam logic [1:0] SHM_FEC = 2'h2;
  // Sync header encodings, first line bit on the left
  localparam logic [1:0] SH_ONE = 2'h1;
  localparam logic [1:0] SH_ZERO = 2'h2;
  // Header stream word layout
  localparam int EXTENDED_MULTIBLOCK_END_FLAG_POS = 22;
  localparam logic [31:0] CRC_ONES = 32'h80A8_8888;
  localparam logic [31:0] FEC_ONES = 32'h8000_0000;
  localparam int FEC_HI_N = 22;
  localparam int FEC_LO_POS = 23;
  localparam int FEC_LO_N = 4;
  // Register port
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_EM1_LSB = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
endpackage
`default_nettype wire

//--- verilog/shf_top.sv
// Transmit sync header framing: multiblocks, extended multiblock clock, header stream
`timescale 1ns/1ps
`default_nettype none
module shf_top (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // SYSREF pin, asynchronous
  input wire logic sysref_i,
  // Scrambled block input
  input wire logic blk_valid_i,
  input wire logic [63:0] blk_data_i,
  // 66-bit block output
  output logic tx_valid_o,
  output logic [65:0] tx_block_o,
  output logic local_extended_multiblock_clock_o,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o
);
  // Synchroniser and SYSREF edge state
  logic sr_meta_r;
  logic sr_sync_r;
  logic sr_prev_r;
  logic sysref_rise;
  // Control register
  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic [1:0] mode_req;
  logic [7:0] emb_m1;
  // Framing counters
  logic [4:0] blk_idx_r;
  logic [4:0] blk_idx_nxt;
  logic [7:0] mb_cnt_r;
  logic [7:0] mb_cnt_nxt;
  logic restart_r;
  logic restart_nxt;
  logic [4:0] cur_idx;
  logic [7:0] cur_mb;
  // Parity snapshots and stream word
  logic [11:0] crc_par_r;
  logic [11:0] crc_par_nxt;
  logic [25:0] fec_par_r;
  logic [25:0] fec_par_nxt;
  logic [31:0] word_r;
  logic [31:0] word_nxt;
  logic [31:0] word_new;
  logic [1:0] mode_eff;
  logic mode_err;
  logic cur_bit;
  // Outputs
  logic tx_valid_nxt;
  logic [65:0] tx_block_nxt;
  logic local_extended_multiblock_clock_nxt;
  logic [31:0] rdata_nxt;

  shf_par_if #(.W(shf_pkg::CRC_W)) crc_if ();
  shf_par_if #(.W(shf_pkg::FEC_W)) fec_if ();

  // Two-flop synchroniser; only the second flop feeds the edge detector
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sr_meta_r <= 1'b0;
      sr_sync_r <= 1'b0;
      sr_prev_r <= 1'b0;
    end else begin
      sr_meta_r <= sysref_i;
      sr_sync_r <= sr_meta_r;
      sr_prev_r <= sr_sync_r;
    end
  end
  assign sysref_rise = sr_sync_r & ~sr_prev_r;

  // Control register write; mode and E take effect at the next multiblock
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (reg_wr_i && reg_addr_i == shf_pkg::REG_CTRL) begin
      ctrl_nxt = reg_wdata_i;
    end
  end
  assign mode_req = ctrl_r[shf_pkg::CTRL_MODE_LSB +: 2];
  assign emb_m1 = ctrl_r[shf_pkg::CTRL_EM1_LSB +: shf_pkg::EMB_W];

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctrl_r <= shf_pkg::CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // Block position; a pending SYSREF makes the next block the first of an extended multiblock
  always_comb begin
    cur_idx = restart_r ? '0 : blk_idx_r;
    cur_mb = restart_r ? '0 : mb_cnt_r;
    blk_idx_nxt = blk_idx_r;
    mb_cnt_nxt = mb_cnt_r;
    restart_nxt = restart_r;
    if (blk_valid_i) begin
      restart_nxt = 1'b0;
      blk_idx_nxt = cur_idx + 5'd1;
      mb_cnt_nxt = cur_mb;
      if (cur_idx == 5'(shf_pkg::MB_BLOCKS - 1)) begin
        mb_cnt_nxt = (cur_mb >= emb_m1) ? '0 : cur_mb + 8'd1;
      end
    end
    // SYSREF seen after the current block wins over the counting
    if (sysref_rise) begin
      restart_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      blk_idx_r <= '0;
      mb_cnt_r <= '0;
      restart_r <= 1'b0;
    end else begin
      blk_idx_r <= blk_idx_nxt;
      mb_cnt_r <= mb_cnt_nxt;
      restart_r <= restart_nxt;
    end
  end

  // Parity feed: header bits never enter, seed cleared at block 0
  assign crc_if.start = (cur_idx == '0);
  assign crc_if.en = blk_valid_i;
  assign crc_if.data = blk_data_i;
  assign fec_if.start = (cur_idx == '0);
  assign fec_if.en = blk_valid_i;
  assign fec_if.data = blk_data_i;

  shf_par_gen #(.W(shf_pkg::CRC_W), .POLY(shf_pkg::CRC_POLY)) u_crc (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .pif(crc_if.gen)
  );

  shf_par_gen #(.W(shf_pkg::FEC_W), .POLY(shf_pkg::FEC_POLY)) u_fec (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .pif(fec_if.gen)
  );

  // Unsupported codes fall back to CRC so the pilot never breaks
  assign mode_err = (mode_req != shf_pkg::SHM_CRC) && (mode_req != shf_pkg::SHM_FEC);
  assign mode_eff = mode_err ? shf_pkg::SHM_CRC : mode_req;

  // Build the next stream word from the previous multiblock's parity
  always_comb begin
    word_new = (mode_eff == shf_pkg::SHM_FEC) ? shf_pkg::FEC_ONES : shf_pkg::CRC_ONES;
    if (mode_eff == shf_pkg::SHM_FEC) begin
      for (int i = 0; i < shf_pkg::FEC_HI_N; i++) begin
        word_new[i] = fec_par_r[shf_pkg::FEC_W - 1 - i];
      end
      for (int j = 0; j < shf_pkg::FEC_LO_N; j++) begin
        word_new[shf_pkg::FEC_LO_POS + j] = fec_par_r[shf_pkg::FEC_LO_N - 1 - j];
      end
    end else begin
      // Parity fills three of every four low bits; command bits stay zero
      for (int k = 0; k < shf_pkg::CRC_W; k++) begin
        word_new[k + k / 3] = crc_par_r[shf_pkg::CRC_W - 1 - k];
      end
    end
    word_new[shf_pkg::EXTENDED_MULTIBLOCK_END_FLAG_POS] = (cur_mb == emb_m1);
  end

  // Parity snapshot at block 31, stream word frozen at block 0
  always_comb begin
    crc_par_nxt = crc_par_r;
    fec_par_nxt = fec_par_r;
    word_nxt = word_r;
    if (blk_valid_i && cur_idx == 5'(shf_pkg::MB_BLOCKS - 1)) begin
      crc_par_nxt = crc_if.par_nxt;
      fec_par_nxt = fec_if.par_nxt;
    end
    if (blk_valid_i && cur_idx == '0) begin
      word_nxt = word_new;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      crc_par_r <= '0;
      fec_par_r <= '0;
      word_r <= '0;
    end else begin
      crc_par_r <= crc_par_nxt;
      fec_par_r <= fec_par_nxt;
      word_r <= word_nxt;
    end
  end

  // Block 0 reads the fresh word; later blocks read the frozen copy
  assign cur_bit = (cur_idx == '0) ? word_new[0] : word_r[cur_idx];

  // Output block and extended multiblock clock pulse
  always_comb begin
    tx_valid_nxt = blk_valid_i;
    tx_block_nxt = tx_block_o;
    local_extended_multiblock_clock_nxt = 1'b0;
    if (blk_valid_i) begin
      tx_block_nxt = {(cur_bit ? shf_pkg::SH_ONE : shf_pkg::SH_ZERO), blk_data_i};
      local_extended_multiblock_clock_nxt = (cur_idx == '0) && (cur_mb == '0);
    end
  end

  // Register read data, one cycle after the strobe; unmapped reads give zero
  always_comb begin
    rdata_nxt = '0;
    if (reg_rd_i) begin
      case (reg_addr_i)
        shf_pkg::REG_CTRL: rdata_nxt = ctrl_r;
        shf_pkg::REG_STAT: rdata_nxt = {15'h0000, mode_err, restart_r, 2'h0, cur_mb, cur_idx};
        default: rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tx_valid_o <= 1'b0;
      tx_block_o <= '0;
      local_extended_multiblock_clock_o <= 1'b0;
      reg_rdata_o <= '0;
    end else begin
      tx_valid_o <= tx_valid_nxt;
      tx_block_o <= tx_block_nxt;
      local_extended_multiblock_clock_o <= local_extended_multiblock_clock_nxt;
      reg_rdata_o <= rdata_nxt;
    end
  end

  // Checks on the framing
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_block_in;
    blk_valid_i;
  endsequence

  sequence s_block_out(logic b);
    tx_valid_o && tx_block_o[65:64] == (b ? 2'h1 : 2'h2);
  endsequence

  // A restart pending when a block arrives
  sequence s_restart_block;
    restart_r && blk_valid_i;
  endsequence

  a_sh_complement: assert property (tx_valid_o |-> tx_block_o[65] != tx_block_o[64])
    else $error("sync header bits not complementary");

  a_sh_bit_map: assert property (s_block_in |=> s_block_out($past(cur_bit)))
    else $error("sync header does not match stream bit");

  // Checks the line headers of blocks 27 to 31, not the constant word bits
  a_pilot_tail: assert property (blk_valid_i && cur_idx >= 5'h1B |=> s_block_out($past(cur_idx) == 5'h1F))
    else $error("stream word tail is not the pilot");

  a_crc_ones: assert property (mode_eff == shf_pkg::SHM_CRC |->
    (word_new & shf_pkg::CRC_ONES) == shf_pkg::CRC_ONES)
    else $error("fixed ones missing in CRC word");

  a_cmd_zero: assert property (mode_eff == shf_pkg::SHM_CRC |->
    word_new[18:16] == 3'h0 && !word_new[20] && word_new[26:24] == 3'h0)
    else $error("command bits not zero");

  a_extended_multiblock_end_flag_flag: assert property (word_new[22] == (cur_mb == emb_m1))
    else $error("extended multiblock end flag wrong");

  a_fec_layout: assert property (mode_eff == shf_pkg::SHM_FEC |->
    word_new[0] == fec_par_r[25] && word_new[26] == fec_par_r[0] && word_new[31])
    else $error("correction word layout wrong");

  a_blk_wrap: assert property (blk_valid_i && cur_idx == 5'h1F && !sysref_rise |=>
    blk_idx_r == 5'h00 && !restart_r)
    else $error("block index did not wrap after 32 blocks");

  a_sysref_phase: assert property (s_restart_block |=> local_extended_multiblock_clock_o && tx_valid_o)
    else $error("SYSREF did not restart the extended multiblock");

  a_mode_fallback: assert property (mode_err |-> mode_eff == shf_pkg::SHM_CRC)
    else $error("unsupported mode not blocked");

  a_crc_snap: assert property (blk_valid_i && cur_idx == 5'h1F |=>
    crc_par_r == $past(crc_if.par_nxt))
    else $error("CRC parity not captured at multiblock end");
endmodule
`default_nettype wire
